// ===== motion_fault_pkg.sv
// ----------------------------------------------------------------------------
// shared constants and types for the fault reaction block
// ----------------------------------------------------------------------------
package motion_fault_pkg;

  // --------------------------------------------------------------------------
  // bus geometry
  // --------------------------------------------------------------------------
  localparam int ADDR_W = 18;                       // byte address width
  localparam int DATA_W = 32;                       // bus data width

  // --------------------------------------------------------------------------
  // register indices, byte address is four times the index
  // --------------------------------------------------------------------------
  localparam logic [15:0] IDX_DEV_CODE   = 16'h3700; // deviation option code
  localparam logic [15:0] IDX_LIM_CODE   = 16'h3701; // limit switch option code
  localparam logic [15:0] IDX_EEP_SIZE   = 16'h4012; // eeprom size readout
  localparam logic [15:0] IDX_HW_CONFIG  = 16'h4013; // hardware configuration
  localparam logic [15:0] IDX_CTRL_WORD  = 16'h6040; // drive control word
  localparam logic [15:0] IDX_STAT_WORD  = 16'h6041; // drive status word
  localparam logic [15:0] IDX_FAST_DECEL = 16'h6085; // fast halt deceleration
  localparam logic [15:0] IDX_IRQ_STAT   = 16'h7000; // sticky event bits
  localparam logic [15:0] IDX_IRQ_MASK   = 16'h7001; // event mask

  // --------------------------------------------------------------------------
  // option code values
  // --------------------------------------------------------------------------
  localparam logic [15:0] CODE_NONE       = 16'hffff; // no reaction (-1)
  localparam logic [15:0] CODE_COAST      = 16'h0000; // power off, free run
  localparam logic [15:0] CODE_SLOW       = 16'h0001; // slow-down ramp
  localparam logic [15:0] CODE_QUICK      = 16'h0002; // quick-stop ramp
  localparam logic [15:0] CODE_SLOW_HALT  = 16'h0005; // slow ramp, then halt
  localparam logic [15:0] CODE_QUICK_HALT = 16'h0006; // quick ramp, then halt

  // --------------------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------------------
  localparam logic [15:0] RST_DEV_CODE   = 16'hffff;
  localparam logic [15:0] RST_LIM_CODE   = 16'hffff;
  localparam logic [15:0] RST_CTRL_WORD  = 16'h0000;
  localparam logic [31:0] RST_FAST_DECEL = 32'h0000_0000;
  localparam logic [2:0]  RST_IRQ_MASK   = 3'h0;

  // --------------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------------
  localparam int CTRL_QS_BIT    = 2;                // quick-stop bit, 1 = not active
  localparam int CTRL_EN_BIT    = 3;                // enable operation
  localparam int CTRL_FR_BIT    = 7;                // clear the warning
  localparam int STAT_WARN_BIT  = 7;                // warning flag
  localparam int STAT_STATE_LSB = 8;                // one-hot drive state field
  localparam int IRQ_W          = 3;                // number of event bits
  localparam int IRQ_DEV        = 0;                // deviation error seen
  localparam int IRQ_LIM        = 1;                // limit switch passed
  localparam int IRQ_HALT       = 2;                // drive came to rest

  // --------------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic              wr;                          // write strobe
    logic              rd;                          // read strobe
    logic [ADDR_W-1:0] addr;                        // byte address
    logic [DATA_W-1:0] wdata;                       // write data
  } reg_req_t;

  typedef enum logic [4:0] {
    ST_LOCKED = 5'h01,                              // power stage locked
    ST_RUN    = 5'h02,                              // operation enabled
    ST_BRAKE  = 5'h04,                              // ramp in progress
    ST_QSTOP  = 5'h08,                              // emergency halt, energized
    ST_COAST  = 5'h10                               // drive function blocked
  } drive_state_t;

  typedef struct packed {
    logic slow;                                     // slow-down ramp request
    logic quick;                                    // quick-stop ramp request
  } brake_cmd_t;

  typedef struct packed {
    logic act;                                      // some reaction is due
    logic coast;                                    // unpower at once
    logic quick;                                    // use quick-stop ramp
    logic to_qstop;                                 // end in emergency halt
  } reaction_t;

endpackage : motion_fault_pkg

// ===== motion_fault_reaction_select.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/1ns
module motion_fault_reaction_select
  import motion_fault_pkg::*;
#(
  parameter logic [31:0] HW_CONFIG = 32'h0000_0000  // hardware configuration readout
) (
  input  wire logic          clk_sys_i,       // 20 MHz system clock
  input  wire logic          rst_n_i,         // synchronous reset, active low
  input  wire reg_req_t      bus_req_i,       // register request
  output logic [DATA_W-1:0]  rd_data_o,       // read data, cycle after read
  input  wire logic          following_err_i, // following error level
  input  wire logic          slippage_err_i,  // slippage error level
  input  wire logic          limit_switch_i,  // limit switch pin
  input  wire logic          ramp_done_i,     // ramp generator reached rest
  input  wire logic [31:0]   eeprom_size_i,   // detected eeprom size in bytes
  output drive_state_t       drive_state_o,   // current drive state
  output logic               power_on_o,      // motor energized
  output brake_cmd_t         brake_o,         // ramp selection while braking
  output logic [31:0]        fast_decel_o,    // fast halt deceleration setting
  output logic               warning_o,       // status word warning bit
  output logic               irq_o            // level interrupt
);

  // --------------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------------
  logic [15:0] idx;                           // register index of the request
  logic        aligned;                       // byte address is word aligned
  logic        wr_en;                         // write strobe, aligned
  logic        rd_en;                         // read strobe, aligned

  assign idx     = bus_req_i.addr[ADDR_W-1:2];
  assign aligned = (bus_req_i.addr[1:0] == 2'h0);
  assign wr_en   = bus_req_i.wr & aligned;
  assign rd_en   = bus_req_i.rd & aligned;

  // --------------------------------------------------------------------------
  // software registers
  // --------------------------------------------------------------------------
  logic [15:0]      dev_code_q;               // deviation option code
  logic [15:0]      lim_code_q;               // limit switch option code
  logic [15:0]      ctrl_q;                   // drive control word
  logic [31:0]      decel_q;                  // fast halt deceleration
  logic [IRQ_W-1:0] irq_mask_q;               // interrupt mask
  logic             ctrl_wr;                  // control word written this cycle

  assign ctrl_wr = wr_en & (idx == IDX_CTRL_WORD);

  // option codes are stored as written, reserved values included
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      dev_code_q <= RST_DEV_CODE;
      lim_code_q <= RST_LIM_CODE;
    end else if (wr_en) begin
      if (idx == IDX_DEV_CODE) begin
        dev_code_q <= bus_req_i.wdata[15:0];
      end
      if (idx == IDX_LIM_CODE) begin
        lim_code_q <= bus_req_i.wdata[15:0];
      end
    end
  end

  // control word changes only on a write, never by the state machine
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ctrl_q <= RST_CTRL_WORD;
    end else if (ctrl_wr) begin
      ctrl_q <= bus_req_i.wdata[15:0];
    end
  end

  // deceleration setting and interrupt mask
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      decel_q    <= RST_FAST_DECEL;
      irq_mask_q <= RST_IRQ_MASK;
    end else if (wr_en) begin
      if (idx == IDX_FAST_DECEL) begin
        decel_q <= bus_req_i.wdata;
      end
      if (idx == IDX_IRQ_MASK) begin
        irq_mask_q <= bus_req_i.wdata[IRQ_W-1:0];
      end
    end
  end

  // eeprom size is sampled every cycle so a late detection shows up
  logic [31:0] eep_size_q;                    // eeprom size readout

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      eep_size_q <= 32'h0000_0000;
    end else begin
      eep_size_q <= eeprom_size_i;
    end
  end

  // --------------------------------------------------------------------------
  // event detection
  // --------------------------------------------------------------------------
  logic lim_meta_q;                           // first synchroniser stage
  logic lim_sync_q;                           // second synchroniser stage
  logic lim_prev_q;                           // previous synchronised level
  logic dev_prev_q;                           // previous deviation level
  logic dev_lvl;                              // any deviation error present
  logic dev_evt;                              // deviation error onset
  logic lim_evt;                              // limit switch reached

  // the limit switch is a pin: two stages before anything looks at it
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      lim_meta_q <= 1'b0;
      lim_sync_q <= 1'b0;
      lim_prev_q <= 1'b0;
    end else begin
      lim_meta_q <= limit_switch_i;
      lim_sync_q <= lim_meta_q;
      lim_prev_q <= lim_sync_q;
    end
  end

  // error levels come from the same clock domain, edge detect only
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      dev_prev_q <= 1'b0;
    end else begin
      dev_prev_q <= dev_lvl;
    end
  end

  assign dev_lvl = following_err_i | slippage_err_i;
  assign dev_evt = dev_lvl & ~dev_prev_q;
  assign lim_evt = lim_sync_q & ~lim_prev_q;

  // --------------------------------------------------------------------------
  // reaction decode
  // --------------------------------------------------------------------------
  // deviation codes: anything outside 0..2 is reserved and does nothing
  function automatic reaction_t dev_reaction(input logic [15:0] code);
    reaction_t r;
    r = '0;
    case (code)
      CODE_COAST: begin
        r.act   = 1'b1;
        r.coast = 1'b1;
      end
      CODE_SLOW: begin
        r.act   = 1'b1;
      end
      CODE_QUICK: begin
        r.act   = 1'b1;
        r.quick = 1'b1;
      end
      default: r = '0;
    endcase
    return r;
  endfunction : dev_reaction

  // limit codes: -1 and the unlisted values leave the drive alone
  function automatic reaction_t lim_reaction(input logic [15:0] code);
    reaction_t r;
    r = '0;
    case (code)
      CODE_NONE: r = '0;
      CODE_SLOW: begin
        r.act = 1'b1;
      end
      CODE_QUICK: begin
        r.act   = 1'b1;
        r.quick = 1'b1;
      end
      CODE_SLOW_HALT: begin
        r.act      = 1'b1;
        r.to_qstop = 1'b1;
      end
      CODE_QUICK_HALT: begin
        r.act      = 1'b1;
        r.quick    = 1'b1;
        r.to_qstop = 1'b1;
      end
      default: r = '0;
    endcase
    return r;
  endfunction : lim_reaction

  reaction_t dev_r;                           // reaction to a deviation onset
  reaction_t lim_r;                           // reaction to a limit crossing
  reaction_t react;                           // reaction taken this cycle

  // deviation wins when both strike in one cycle unless its code is reserved: coasting is the safer bet
  always_comb begin
    dev_r = dev_evt ? dev_reaction(dev_code_q) : '0;
    lim_r = lim_evt ? lim_reaction(lim_code_q) : '0;
    react = dev_r.act ? dev_r : lim_r;
  end

  // --------------------------------------------------------------------------
  // drive state machine
  // --------------------------------------------------------------------------
  drive_state_t state_q;                      // current drive state
  logic         to_qstop_q;                   // braking ends in emergency halt
  brake_cmd_t   brake_q;                      // active ramp choice
  logic         qs_armed_q;                   // quick-stop bit seen at 0 in halt
  logic         qs_release;                   // halt left on 0 then 1
  logic         en_write;                     // master asks for operation
  logic         halt_evt;                     // drive came to rest by a reaction

  assign en_write   = ctrl_wr & bus_req_i.wdata[CTRL_EN_BIT] & bus_req_i.wdata[CTRL_QS_BIT];
  assign qs_release = ctrl_wr & qs_armed_q & bus_req_i.wdata[CTRL_QS_BIT];
  assign halt_evt   = ((state_q == ST_BRAKE) & ramp_done_i)
                    | ((state_q == ST_RUN) & react.act & react.coast);

  // reactions are acted on only while running; other states are braking or at rest
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_q <= ST_LOCKED;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (react.act) begin
            state_q <= react.coast ? ST_COAST : ST_BRAKE;
          end
        end
        ST_BRAKE: begin
          if (ramp_done_i) begin
            state_q <= to_qstop_q ? ST_QSTOP : ST_LOCKED;
          end
        end
        ST_QSTOP: begin
          if (qs_release) begin
            state_q <= ST_RUN;
          end
        end
        ST_LOCKED, ST_COAST: begin
          if (en_write) begin
            state_q <= ST_RUN;
          end
        end
        default: state_q <= ST_LOCKED;
      endcase
    end
  end

  // ramp choice and end state are latched when braking starts
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      brake_q    <= '0;
      to_qstop_q <= 1'b0;
    end else if ((state_q == ST_RUN) & react.act & ~react.coast) begin
      brake_q.slow  <= ~react.quick;
      brake_q.quick <= react.quick;
      to_qstop_q    <= react.to_qstop;
    end else if ((state_q == ST_BRAKE) & ramp_done_i) begin
      brake_q       <= '0;
    end
  end

  // return from halt needs a fresh 0 write of the quick-stop bit first
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      qs_armed_q <= 1'b0;
    end else if (state_q != ST_QSTOP) begin
      qs_armed_q <= 1'b0;
    end else if (ctrl_wr & ~bus_req_i.wdata[CTRL_QS_BIT]) begin
      qs_armed_q <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // warning flag
  // --------------------------------------------------------------------------
  logic warn_q;                               // status word warning bit

  // set on every crossing, whatever the code; a clear in the same cycle loses
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      warn_q <= 1'b0;
    end else if (lim_evt) begin
      warn_q <= 1'b1;
    end else if (ctrl_wr & bus_req_i.wdata[CTRL_FR_BIT]) begin
      warn_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // interrupt status
  // --------------------------------------------------------------------------
  logic [IRQ_W-1:0] irq_stat_q;               // sticky event bits
  logic [IRQ_W-1:0] irq_set;                  // events of this cycle
  logic             irq_rd;                   // status register read

  assign irq_set[IRQ_DEV]  = dev_evt;
  assign irq_set[IRQ_LIM]  = lim_evt;
  assign irq_set[IRQ_HALT] = halt_evt;
  assign irq_rd            = rd_en & (idx == IDX_IRQ_STAT);

  // read clears, but an event arriving with the read stays set
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      irq_stat_q <= '0;
    end else if (irq_rd) begin
      irq_stat_q <= irq_set;
    end else begin
      irq_stat_q <= irq_stat_q | irq_set;
    end
  end

  // --------------------------------------------------------------------------
  // read data
  // --------------------------------------------------------------------------
  logic [15:0] stat_word;                     // assembled status word

  always_comb begin
    stat_word                                  = 16'h0000;
    stat_word[STAT_WARN_BIT]                   = warn_q;
    stat_word[STAT_STATE_LSB+4:STAT_STATE_LSB] = state_q;
  end

  // unmapped or misaligned reads return zero
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rd_data_o <= '0;
    end else if (rd_en) begin
      case (idx)
        IDX_DEV_CODE:   rd_data_o <= {16'h0000, dev_code_q};
        IDX_LIM_CODE:   rd_data_o <= {16'h0000, lim_code_q};
        IDX_EEP_SIZE:   rd_data_o <= eep_size_q;
        IDX_HW_CONFIG:  rd_data_o <= HW_CONFIG;
        IDX_CTRL_WORD:  rd_data_o <= {16'h0000, ctrl_q};
        IDX_STAT_WORD:  rd_data_o <= {16'h0000, stat_word};
        IDX_FAST_DECEL: rd_data_o <= decel_q;
        IDX_IRQ_STAT:   rd_data_o <= {{(DATA_W-IRQ_W){1'b0}}, irq_stat_q};
        IDX_IRQ_MASK:   rd_data_o <= {{(DATA_W-IRQ_W){1'b0}}, irq_mask_q};
        default:        rd_data_o <= '0;
      endcase
    end else begin
      rd_data_o <= '0;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  // locked and coasting leave the motor unpowered; halt keeps it energized
  assign power_on_o    = (state_q != ST_LOCKED) & (state_q != ST_COAST);
  assign drive_state_o = state_q;
  assign brake_o       = brake_q;
  assign fast_decel_o  = decel_q;
  assign warning_o     = warn_q;
  assign irq_o         = |(irq_stat_q & irq_mask_q);

endmodule : motion_fault_reaction_select

// ===== motion_fault_assertions.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// port checker for the fault reaction block
// ----------------------------------------------------------------------------
module motion_fault_checker
  import motion_fault_pkg::*;
(
  input wire logic              clk_sys_i,      // system clock
  input wire logic              rst_n_i,        // synchronous reset, active low
  input wire reg_req_t          bus_req_i,      // register request
  input wire logic [DATA_W-1:0] rd_data_o,      // read data
  input wire logic              limit_switch_i, // limit switch pin
  input wire logic              ramp_done_i,    // ramp reached rest
  input wire logic [31:0]       eeprom_size_i,  // detected eeprom size
  input wire drive_state_t      drive_state_o,  // drive state
  input wire logic              power_on_o,     // motor energized
  input wire brake_cmd_t        brake_o,        // ramp selection
  input wire logic              warning_o       // status word warning
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // exactly one ramp is chosen, and only while braking
  property p_brake_sel; (drive_state_o == ST_BRAKE) == $onehot(brake_o); endproperty
  a_brake_sel: assert property (p_brake_sel)
    else $error("ramp choice does not match braking state");
  // the ramp choice holds until the generator reports rest
  property p_brake_hold;
    drive_state_o == ST_BRAKE && !ramp_done_i |=> drive_state_o == ST_BRAKE && $stable(brake_o);
  endproperty
  a_brake_hold: assert property (p_brake_hold)
    else $error("braking left before rest");
  // after the ramp the drive is locked or in emergency halt
  property p_brake_end;
    drive_state_o == ST_BRAKE && ramp_done_i |=> drive_state_o inside {ST_LOCKED, ST_QSTOP};
  endproperty
  a_brake_end: assert property (p_brake_end)
    else $error("wrong state after braking");
  // motor stays energized while running, braking and in emergency halt
  property p_power;
    power_on_o == (drive_state_o inside {ST_RUN, ST_BRAKE, ST_QSTOP});
  endproperty
  a_power: assert property (p_power)
    else $error("power output does not follow state");
  // a coasting drive is unpowered and never braked
  property p_coast; drive_state_o == ST_COAST |-> !power_on_o && brake_o == 2'h0; endproperty
  a_coast: assert property (p_coast)
    else $error("coasting drive still driven");
  // emergency halt only ever returns to running
  property p_qstop_exit; drive_state_o == ST_QSTOP |=> drive_state_o inside {ST_QSTOP, ST_RUN};
  endproperty
  a_qstop_exit: assert property (p_qstop_exit)
    else $error("emergency halt left to a wrong state");
  // a held limit pin raises the warning within the synchroniser delay
  property p_warn; $rose(limit_switch_i) ##2 limit_switch_i |-> ##[1:6] warning_o; endproperty
  a_warn: assert property (p_warn)
    else $error("no warning after limit switch");
  // read data stand for one cycle only
  property p_rd_idle; !bus_req_i.rd |=> rd_data_o == '0; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read answer");
  // the size readout follows the sampled input
  property p_eep;
    bus_req_i.rd && bus_req_i.addr == {IDX_EEP_SIZE, 2'b00} && $stable(eeprom_size_i)
      && $past(rst_n_i) |=> rd_data_o == $past(eeprom_size_i);
  endproperty
  a_eep: assert property (p_eep)
    else $error("eeprom size readout wrong");
  c_halt: cover property (drive_state_o == ST_BRAKE ##1 drive_state_o == ST_QSTOP);
  c_coast: cover property (drive_state_o == ST_COAST);
  c_warn: cover property ($rose(warning_o));
endmodule : motion_fault_checker

bind motion_fault_reaction_select motion_fault_checker motion_fault_checker_i (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus_req_i(bus_req_i), .rd_data_o(rd_data_o),
  .limit_switch_i(limit_switch_i), .ramp_done_i(ramp_done_i), .eeprom_size_i(eeprom_size_i),
  .drive_state_o(drive_state_o), .power_on_o(power_on_o), .brake_o(brake_o),
  .warning_o(warning_o)
);

// ===== motion_ramp_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// ramp generator stand-in on the braking side
// ----------------------------------------------------------------------------
module motion_ramp_model
  import motion_fault_pkg::*;
(
  input  wire logic       clk_sys_i, // system clock
  input  wire brake_cmd_t brake_i,   // ramp request from the block
  input  wire logic       lazy_i,    // long ramp when high
  output logic            done_o     // drive has come to rest
);
  logic [3:0] cnt_q;                 // cycles spent braking
  // count while a ramp is requested, restart once it ends
  always_ff @(posedge clk_sys_i) begin
    cnt_q <= (brake_i != 2'h0) ? cnt_q + 4'h1 : 4'h0;
  end
  // prompt answer after one cycle, slow one after eight
  assign done_o = (brake_i != 2'h0) && (cnt_q >= (lazy_i ? 4'h8 : 4'h1));
endmodule : motion_ramp_model

// ===== testbench.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// register level tests of the fault reaction block
// ----------------------------------------------------------------------------
module testbench
  import motion_fault_pkg::*;
;
  logic              clk_sys_i = 1'b0, rst_n_i = 1'b0;
  reg_req_t          req = '0;                          // bus request
  logic              fol = 1'b0, slp = 1'b0, lim = 1'b0, lazy = 1'b0;
  logic [31:0]       eep = 32'h0000_2000;               // attached eeprom size
  logic [DATA_W-1:0] rdat;
  logic [31:0]       fdec;
  drive_state_t      st;
  logic              pwr, warn, irq, done;
  brake_cmd_t        brk, seen;
  int                fails = 0, n_checks = 0;
  // limit codes: none, slow, quick, slow halt, quick halt, reserved
  logic [15:0]       lc [6] = '{16'hffff, 16'h0001, 16'h0002, 16'h0005, 16'h0006, 16'h0003};
  drive_state_t      ls [6] = '{ST_RUN, ST_LOCKED, ST_LOCKED, ST_QSTOP, ST_QSTOP, ST_RUN};
  brake_cmd_t        lb [6] = '{2'h0, 2'h2, 2'h1, 2'h2, 2'h1, 2'h0};
  logic [31:0]       li [6] = '{32'h0000_0002, 32'h0000_0006, 32'h0000_0006, 32'h0000_0006,
                                32'h0000_0006, 32'h0000_0002};
  // deviation codes: coast, slow, quick, reserved, negative
  logic [15:0]       dc [5] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'hffff};
  drive_state_t      ds [5] = '{ST_COAST, ST_LOCKED, ST_LOCKED, ST_RUN, ST_RUN};
  brake_cmd_t        db [5] = '{2'h0, 2'h2, 2'h1, 2'h0, 2'h0};
  always #25 clk_sys_i = ~clk_sys_i;
  motion_fault_reaction_select motion_fault_reaction_select_i (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus_req_i(req), .rd_data_o(rdat),
    .following_err_i(fol), .slippage_err_i(slp), .limit_switch_i(lim), .ramp_done_i(done),
    .eeprom_size_i(eep), .drive_state_o(st), .power_on_o(pwr), .brake_o(brk),
    .fast_decel_o(fdec), .warning_o(warn), .irq_o(irq));
  motion_ramp_model motion_ramp_model_i (
    .clk_sys_i(clk_sys_i), .brake_i(brk), .lazy_i(lazy), .done_o(done));
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one-cycle write, strobe dropped at the taking edge
  task wr(input logic [15:0] idx, input logic [31:0] d);
    @(posedge clk_sys_i) req <= '{1'b1, 1'b0, {idx, 2'b00}, d};
    @(posedge clk_sys_i) req.wr <= 1'b0;
  endtask : wr
  // one-cycle read, data looked at in the answer cycle only
  task rd(input logic [15:0] idx, input logic [31:0] e);
    @(posedge clk_sys_i) req <= '{1'b0, 1'b1, {idx, 2'b00}, 32'h0000_0000};
    @(posedge clk_sys_i) req.rd <= 1'b0;
    #1 chk(rdat, e);
  endtask : rd
  // bounded wait for the final state, collecting any ramp choice on the way
  task settle(input drive_state_t e, input brake_cmd_t b);
    seen = 2'h0;
    for (int k = 0; k < 50; k++) begin
      @(posedge clk_sys_i) #1 seen = seen | brk;
      if (k > 6 && st === e) break;
    end
    if (st !== e) begin
      fails++;
      $display("BAD %0t state wait ran out", $time);
      conclude();
    end
    chk(seen, b);
  endtask : settle
  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    wr(IDX_EEP_SIZE, 32'h0000_0000);                 // read-only place keeps its value
    rd(IDX_LIM_CODE, 32'h0000_ffff);
    rd(IDX_DEV_CODE, 32'h0000_ffff);
    rd(IDX_EEP_SIZE, 32'h0000_2000);
    @(posedge clk_sys_i) eep <= 32'h0000_0000;
    rd(IDX_EEP_SIZE, 32'h0000_0000);
    rd(IDX_HW_CONFIG, 32'h0000_0000);
    rd(16'h5000, 32'h0000_0000);
    wr(IDX_FAST_DECEL, 32'h0001_2345);
    #1 chk(fdec, 32'h0001_2345);
    wr(IDX_IRQ_MASK, 32'h0000_0002);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      wr(IDX_LIM_CODE, {16'h0000, lc[i]});
      wr(IDX_CTRL_WORD, 32'h0000_008c);
      #1 chk(st, ST_RUN);
      chk(warn, 1'b0);
      @(posedge clk_sys_i) lim <= 1'b1;
      lazy <= i[0];
      settle(ls[i], lb[i]);
      chk(warn, 1'b1);
      rd(IDX_STAT_WORD, {19'h0, ls[i], 8'h80});
      chk(irq, 1'b1);
      rd(IDX_IRQ_STAT, li[i]);
      chk(irq, 1'b0);
      @(posedge clk_sys_i) lim <= 1'b0;
      if (ls[i] == ST_QSTOP) begin
        rd(IDX_CTRL_WORD, 32'h0000_008c);
        wr(IDX_CTRL_WORD, 32'h0000_0088);
        #1 chk(st, ST_QSTOP);
        wr(IDX_CTRL_WORD, 32'h0000_000c);
        #1 chk(st, ST_RUN);
      end
    end
    $display("test limit switch done");
    for (int i = 0; i < 5; i++) begin
      wr(IDX_DEV_CODE, {16'h0000, dc[i]});
      wr(IDX_CTRL_WORD, 32'h0000_000c);
      #1 chk(st, ST_RUN);
      @(posedge clk_sys_i) {slp, fol} <= i[0] ? 2'b10 : 2'b01;
      lazy <= i[0];
      settle(ds[i], db[i]);
      chk(pwr, ds[i] == ST_RUN);
      chk(irq, 1'b0);
      rd(IDX_IRQ_STAT, {29'h0, ds[i] != ST_RUN, 2'b01});
      @(posedge clk_sys_i) {slp, fol} <= 2'b00;
    end
    $display("test deviation done");
    conclude();
  end
endmodule : testbench
